// ### verilog/spicp_pkg.sv
// spicp_pkg: constants, modes and states of the serial command port
// assumes: shared by the port, its fifo memory and the test bench
package spicp_pkg;
  // byte framing
  localparam int          BYTE_W      = 8;            // bits per byte
  localparam logic [2:0]  BIT_LAST    = 3'h7;         // index of the eighth bit
  // mode field of the first byte
  localparam logic [1:0]  MODE_REG_WR = 2'h0;         // register write
  localparam logic [1:0]  MODE_REG_RD = 2'h1;         // register read
  localparam logic [1:0]  MODE_FIFO   = 2'h2;         // fifo load or read
  localparam logic [1:0]  MODE_CMD    = 2'h3;         // direct command
  localparam logic [5:0]  TRL_LOAD    = 6'h00;        // trailer for fifo load
  localparam logic [5:0]  TRL_READ    = 6'h3F;        // trailer for fifo read
  localparam logic [5:0]  ADDR_STEP   = 6'h01;        // auto-increment step
  // register map
  localparam int          REG_NUM     = 8;            // plain read/write registers
  localparam logic [5:0]  REG_LAST    = 6'h07;        // highest plain register
  localparam logic [5:0]  ADR_IOCFG   = 6'h01;        // io configuration
  localparam logic [5:0]  ADR_OPCTL   = 6'h02;        // operation control
  localparam logic [5:0]  ADR_STATUS  = 6'h08;        // read-only fifo count
  localparam int          OPCTL_EN    = 7;            // operation enable bit
  localparam int          IOCFG_PD_A  = 4;            // pull-down option a
  localparam int          IOCFG_PD_B  = 3;            // pull-down option b
  localparam logic [7:0]  REG_RST     = 8'h00;        // register reset value
  // direct commands at or above this code run long (value arbitrary)
  localparam logic [5:0]  CMD_LONG_MIN = 6'h30;
  // fifo geometry
  localparam int          FIFO_DEPTH  = 96;           // bytes
  localparam int          PTR_W       = 7;            // pointer width
  localparam logic [6:0]  PTR_LAST    = 7'h5F;        // last entry index
  localparam logic [6:0]  PTR_STEP    = 7'h01;        // pointer step
  localparam logic [6:0]  CNT_FULL    = 7'h60;        // count when full

  // port states, one-hot
  typedef enum logic [5:0] {
    ST_MODE  = 6'b000001,  // expecting a mode byte
    ST_WRITE = 6'b000010,  // register write data
    ST_READ  = 6'b000100,  // register read data
    ST_FLOAD = 6'b001000,  // fifo load data
    ST_FREAD = 6'b010000,  // fifo read data
    ST_SKIP  = 6'b100000   // refused frame, ignore till deselect
  } spicp_state_t;
endpackage : spicp_pkg

// ### verilog/spicp_fifo_mem.sv
// spicp_fifo_mem: byte storage of the 96 entry fifo
// assumes: one write and one read address per cycle, same clock as the port
`timescale 1ns/1ps
`default_nettype none
module spicp_fifo_mem
  import spicp_pkg::*;
(
  input  wire logic              core_clk_in,   // port clock
  input  wire logic              rstn_in,       // synchronous reset, low active
  input  wire logic              we_in,         // write enable
  input  wire logic [PTR_W-1:0]  waddr_in,      // write address
  input  wire logic [7:0]        wdata_in,      // write data
  input  wire logic [PTR_W-1:0]  raddr_in,      // read address
  output logic      [7:0]        rdata_out      // registered read data
);
  logic [7:0] mem_q [FIFO_DEPTH];  // storage array, not reset

  // write port
  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // read port through an output register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end
endmodule : spicp_fifo_mem
`default_nettype wire

// ### verilog/spicp_port.sv
// spicp_port: four-wire serial slave port with register, fifo and command modes
// assumes: sclk well below core_clk_in/4; pins asynchronous; core logic same clock
// What this block does
// - deselect holds port in reset
// - input sampled on falling serial clock
// - bytes of eight bits, msb first
// - first byte's two top bits pick mode
// - 00 write, 01 read, six address bits
// - further data bytes use next address
// - write commits on eighth falling edge
// - partial write byte leaves register unchanged
// - unmapped or read-only writes discarded
// - read data launched on rising edge
// - unmapped reads return zero
// - output tristated except while shifting data
// - option bits enable pull-down while tristated
// - mode 10 trailer zeros loads fifo
// - partial load byte not stored
// - mode 10 trailer ones reads fifo
// - partial fifo read byte stays unread
// - fifo needs enable bit and stable oscillator
// - mode 11 runs six-bit direct command
// - interrupt when long command finishes
// - immediate command may chain next mode
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module spicp_port
  import spicp_pkg::*;
(
  input  wire logic        core_clk_in,        // 10 MHz clock
  input  wire logic        rstn_in,            // synchronous reset, low active
  input  wire logic        sel_n_in,           // chip select pin, low active
  input  wire logic        sclk_in,            // serial clock pin
  input  wire logic        mosi_in,            // serial data in pin
  output logic             miso_out,           // serial data out
  output logic             miso_oe_out,        // high while driving serial out
  output logic             pulldown_en_out,    // pull-down request on serial out
  input  wire logic        xtal_stable_in,     // oscillator stable, asynchronous
  input  wire logic        cmd_busy_in,        // command unit busy
  output logic             cmd_strobe_out,     // one-cycle command pulse
  output logic [5:0]       cmd_code_out,       // command code
  output logic             irq_out,            // long command finished
  input  wire logic [5:0]  core_addr_in,       // core register address
  input  wire logic [7:0]  core_wdata_in,      // core write data
  input  wire logic        core_wr_in,         // core write strobe
  input  wire logic        core_rd_in,         // core read strobe
  output logic [7:0]       core_rdata_out,     // core read data, next cycle
  input  wire logic        core_push_in,       // core pushes a fifo byte
  input  wire logic [7:0]  core_push_data_in,  // byte to push
  input  wire logic        core_pop_in,        // core pops the fifo head
  output logic [7:0]       core_head_out,      // fifo head byte
  output logic [6:0]       fifo_count_out      // bytes held in fifo
);
  // whole state of the port
  typedef struct packed {
    logic              ss_s1, ss_s2, ss_p;        // select synchroniser and history
    logic              ck_s1, ck_s2, ck_p;        // serial clock synchroniser
    logic              di_s1, di_s2;              // data in synchroniser
    logic              xt_s1, xt_s2;              // oscillator flag synchroniser
    spicp_state_t      st;                        // port state
    logic [2:0]        bitcnt;                    // bit within byte
    logic [6:0]        rx_sh;                     // incoming bits
    logic [5:0]        addr;                      // register address
    logic [7:0]        tx_sh;                     // outgoing bits
    logic              miso;                      // output bit
    logic              oe;                        // output drive
    logic              reload;                    // fetch next fifo head
    logic [6:0]        wr_ptr, rd_ptr, cnt;       // fifo pointers and count
    logic [REG_NUM-1:0][7:0] regs;                // register storage
    logic              cmd_stb;                   // command pulse
    logic [5:0]        cmd_code;                  // last command code
    logic              long_pend;                 // long command running
    logic              busy_p;                    // previous busy
    logic              irq;                       // finish flag
    logic [7:0]        rdata;                     // core read data
  } spicp_port_t;

  spicp_port_t q, d;           // registered and next state
  logic        fall, rise;     // serial clock edges
  logic        byte_end;       // eighth bit arrives now
  logic [7:0]  byte_in;        // completed byte
  logic        fifo_ok;        // fifo modes allowed
  logic        spi_push;       // spi stores a byte in the fifo
  logic        spi_pop;        // spi consumes the fifo head
  logic        core_push;      // accepted core push
  logic        core_pop;       // accepted core pop
  logic        wr_fire;        // register write takes place
  logic [7:0]  fifo_rdata;     // fifo head from memory
  logic        mem_we;         // memory write enable
  logic [7:0]  mem_wdata;      // memory write data

  // register read mux, zero where nothing is mapped
  function automatic logic [7:0] reg_read(input spicp_port_t s, input logic [5:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a <= REG_LAST) begin
      v = s.regs[a[2:0]];
    end else if (a == ADR_STATUS) begin
      v = {1'b0, s.cnt};
    end
    return v;
  endfunction : reg_read

  spicp_fifo_mem u_mem (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .we_in       (mem_we),
    .waddr_in    (q.wr_ptr),
    .wdata_in    (mem_wdata),
    .raddr_in    (d.rd_ptr),
    .rdata_out   (fifo_rdata)
  );

  // next-state logic
  always_comb begin
    d         = q;
    d.ss_s1   = sel_n_in;
    d.ss_s2   = q.ss_s1;
    d.ss_p    = q.ss_s2;
    d.ck_s1   = sclk_in;
    d.ck_s2   = q.ck_s1;
    d.ck_p    = q.ck_s2;
    d.di_s1   = mosi_in;
    d.di_s2   = q.di_s1;
    d.xt_s1   = xtal_stable_in;
    d.xt_s2   = q.xt_s1;
    d.cmd_stb = 1'b0;
    d.reload  = 1'b0;
    d.busy_p  = cmd_busy_in;
    fall      = q.ck_p & ~q.ck_s2 & ~q.ss_s2;
    rise      = ~q.ck_p & q.ck_s2 & ~q.ss_s2;
    byte_end  = fall && (q.bitcnt == BIT_LAST);
    byte_in   = {q.rx_sh, q.di_s2};
    fifo_ok   = q.regs[ADR_OPCTL[2:0]][OPCTL_EN] & q.xt_s2;
    spi_push  = 1'b0;
    spi_pop   = 1'b0;
    wr_fire   = 1'b0;
    // spi side
    if (q.ss_s2) begin
      // deselected: counters and state held in reset
      d.st     = ST_MODE;
      d.bitcnt = 3'h0;
      d.oe     = 1'b0;
    end else if (fall) begin
      // sample data in on the falling serial clock
      d.rx_sh  = byte_in[6:0];
      d.bitcnt = q.bitcnt + 3'h1;
      if (byte_end) begin
        case (q.st)
          ST_MODE: begin
            // decode the mode byte
            d.addr = byte_in[5:0];
            case (byte_in[7:6])
              MODE_REG_WR: d.st = ST_WRITE;
              MODE_REG_RD: begin
                d.st    = ST_READ;
                d.tx_sh = reg_read(q, byte_in[5:0]);
              end
              MODE_FIFO: begin
                if (fifo_ok && byte_in[5:0] == TRL_LOAD) begin
                  d.st = ST_FLOAD;
                end else if (fifo_ok && byte_in[5:0] == TRL_READ) begin
                  d.st    = ST_FREAD;
                  d.tx_sh = (q.cnt != 7'h00) ? fifo_rdata : 8'h00;
                end else begin
                  d.st = ST_SKIP;
                end
              end
              default: begin
                // direct command, next byte is again a mode byte
                d.cmd_stb  = 1'b1;
                d.cmd_code = byte_in[5:0];
                d.st       = ST_MODE;
                if (byte_in[5:0] >= CMD_LONG_MIN) begin
                  d.long_pend = 1'b1;
                end
              end
            endcase
          end
          ST_WRITE: begin
            // commit on the eighth bit only, mapped writable registers only
            wr_fire = (q.addr <= REG_LAST);
            if (wr_fire) begin
              d.regs[q.addr[2:0]] = byte_in;
            end
            d.addr = q.addr + ADDR_STEP;
          end
          ST_READ: begin
            d.addr  = q.addr + ADDR_STEP;
            d.tx_sh = reg_read(q, q.addr + ADDR_STEP);
          end
          ST_FLOAD: begin
            spi_push = (q.cnt != CNT_FULL);
          end
          ST_FREAD: begin
            // byte fully shifted, consume it and fetch the next head
            spi_pop  = (q.cnt != 7'h00);
            d.reload = 1'b1;
          end
          ST_SKIP: d.st = ST_SKIP;
          default: d.st = ST_MODE;
        endcase
      end
    end else if (rise && (q.st == ST_READ || q.st == ST_FREAD)) begin
      // launch the next output bit on the rising serial clock
      d.miso  = q.tx_sh[BYTE_W-1];
      d.tx_sh = {q.tx_sh[6:0], 1'b0};
      d.oe    = 1'b1;
    end
    if (q.reload) begin
      d.tx_sh = (q.cnt != 7'h00) ? fifo_rdata : 8'h00;
    end
    // core side works on the fifo only while the port is deselected
    core_push = core_push_in & q.ss_s2 & (q.cnt != CNT_FULL);
    core_pop  = core_pop_in & q.ss_s2 & (q.cnt != 7'h00);
    mem_we    = spi_push | core_push;
    mem_wdata = spi_push ? byte_in : core_push_data_in;
    if (mem_we) begin
      d.wr_ptr = (q.wr_ptr == PTR_LAST) ? 7'h00 : q.wr_ptr + PTR_STEP;
    end
    if (spi_pop | core_pop) begin
      d.rd_ptr = (q.rd_ptr == PTR_LAST) ? 7'h00 : q.rd_ptr + PTR_STEP;
    end
    case ({mem_we, spi_pop | core_pop})
      2'b10:   d.cnt = q.cnt + PTR_STEP;
      2'b01:   d.cnt = q.cnt - PTR_STEP;
      default: d.cnt = q.cnt;
    endcase
    // core register port, spi write wins a collision
    if (core_wr_in && !wr_fire && core_addr_in <= REG_LAST) begin
      d.regs[core_addr_in[2:0]] = core_wdata_in;
    end
    if (core_rd_in) begin
      d.rdata = reg_read(q, core_addr_in);
    end
    // finish of a long command raises the flag; a new frame clears it
    if (q.long_pend && q.busy_p && !cmd_busy_in) begin
      d.long_pend = 1'b0;
      d.irq       = 1'b1;
    end else if (q.ss_p && !q.ss_s2) begin
      d.irq = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      q      <= '0;
      q.ss_s1 <= 1'b1;
      q.ss_s2 <= 1'b1;
      q.ss_p  <= 1'b1;
      q.st    <= ST_MODE;
      q.regs  <= {REG_NUM{REG_RST}};
    end else begin
      q <= d;
    end
  end

  // outputs
  assign miso_out        = q.miso;
  assign miso_oe_out     = q.oe;
  assign pulldown_en_out = (q.regs[ADR_IOCFG[2:0]][IOCFG_PD_A]
                           | q.regs[ADR_IOCFG[2:0]][IOCFG_PD_B]) & ~q.oe;
  assign cmd_strobe_out  = q.cmd_stb;
  assign cmd_code_out    = q.cmd_code;
  assign irq_out         = q.irq;
  assign core_rdata_out  = q.rdata;
  assign core_head_out   = fifo_rdata;
  assign fifo_count_out  = q.cnt;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_byte_done;
    !q.ss_s2 && q.ck_p && !q.ck_s2 && q.bitcnt == BIT_LAST;
  endsequence
  sequence s_deselect;
    q.ss_s2;
  endsequence

  AST_SEL_RESET: assert property (s_deselect |=> q.st == ST_MODE && q.bitcnt == 3'h0 && !q.oe)
    else $error("port not reset while deselected");
  AST_SEL_FALL: assert property ($fell(q.ss_s2) |-> q.bitcnt == 3'h0 && q.st == ST_MODE)
    else $error("new frame does not start at a mode byte");
  AST_SHIFT_HOLD: assert property (!fall && !q.ss_s2 |=> q.rx_sh == $past(q.rx_sh))
    else $error("input shifted without falling clock");
  AST_WR_COMMIT: assert property (wr_fire |=> q.regs[$past(q.addr[2:0])] == $past(byte_in))
    else $error("register write not committed");
  AST_ADDR_INC: assert property (s_byte_done ##0 (q.st == ST_WRITE || q.st == ST_READ)
                                 |=> q.addr == $past(q.addr) + ADDR_STEP)
    else $error("address not incremented");
  AST_OE_ONLY_READ: assert property (q.oe |-> (q.st == ST_READ || q.st == ST_FREAD))
    else $error("output driven outside read data");
  AST_PULLDOWN: assert property (pulldown_en_out |-> !miso_oe_out)
    else $error("pull-down while driving");
  AST_PUSH_CNT: assert property (spi_push |=> q.cnt == $past(q.cnt) + PTR_STEP)
    else $error("fifo count not incremented on load");
  AST_FREAD_ABORT: assert property (q.st == ST_FREAD && !byte_end ##1 s_deselect
                                    |-> q.rd_ptr == $past(q.rd_ptr))
    else $error("partial fifo read consumed a byte");
  AST_FIFO_GATE: assert property (s_byte_done ##0 q.st == ST_MODE && byte_in[7:6] == MODE_FIFO
                                  && !fifo_ok |=> q.st == ST_SKIP)
    else $error("fifo mode entered while not allowed");
  AST_CMD_CHAIN: assert property (q.cmd_stb |-> q.st == ST_MODE ##1 !q.cmd_stb)
    else $error("command pulse wrong");
  AST_IRQ: assert property (q.long_pend && q.busy_p && !cmd_busy_in |=> irq_out)
    else $error("no interrupt after long command");
endmodule : spicp_port
`default_nettype wire

// ### dv/spicp_master.sv
// spicp_master: behavioural serial master that stands in for the microcontroller
// assumes: bench calls its tasks one at a time; link clock period 800 ns, idle low
`timescale 1ns/1ps
`default_nettype none
module spicp_master (
  input  wire logic        core_clk_in,     // paces the floating-line pattern
  input  wire logic        miso_in,         // serial data from the port
  input  wire logic        miso_oe_in,      // port drives the line
  input  wire logic        pulldown_en_in,  // pull-down on the released line
  output logic             sel_n_out,       // chip select, low active
  output logic             sclk_out,        // serial clock, stands low outside frames
  output logic             mosi_out,        // serial data to the port
  output logic             rx_vld_out,      // pulse after a kept byte
  output logic [7:0]       rx_byte_out      // byte seen on the line
);
  logic alt_q;  // changing pattern for a released, unpulled line
  logic line;   // resolved level of the serial output wire
  initial begin
    alt_q       = 1'b0;
    sel_n_out   = 1'b1;
    sclk_out    = 1'b0;
    mosi_out    = 1'b0;
    rx_vld_out  = 1'b0;
    rx_byte_out = 8'h00;
  end
  // toggling filler so a released line never shows a stale bit
  always @(posedge core_clk_in) alt_q <= ~alt_q;
  // released line reads low when pulled down, else the filler
  assign line = miso_oe_in ? miso_in : (pulldown_en_in ? 1'b0 : alt_q);
  // select low, then give the synchroniser time before the first clock
  task frame_open;
    sel_n_out = 1'b0;
    #500;
  endtask : frame_open
  // let the last byte land, deselect and leave the data line inverted
  task frame_close;
    #800;
    sel_n_out = 1'b1;
    mosi_out  = ~mosi_out;
    #1000;
  endtask : frame_close
  // nbits of tx, msb first; data changes on the rising clock so that it
  // still stands across the falling edge at which the port samples it
  task xfer(input logic [7:0] tx, input int nbits, input bit keep);
    for (int i = 7; i > 7 - nbits; i--) begin
      #400 sclk_out = 1'b1;
      mosi_out = tx[i];
      #400 sclk_out = 1'b0;
      rx_byte_out[i] = line;
    end
    if (keep) begin
      rx_vld_out = 1'b1;
      #50 rx_vld_out = 1'b0;
    end
  endtask : xfer
endmodule : spicp_master
`default_nettype wire

// ### dv/test_spicp_port.sv
// test_spicp_port: self-checking bench of the serial command port
// assumes: master model drives the pins; core side driven here on rising edges
`timescale 1ns/1ps
`default_nettype none
module test_spicp_port;
  import spicp_pkg::*;
  logic       core_clk_in = 1'b0;  // 10 MHz clock
  logic       rstn_in     = 1'b0;  // synchronous reset
  logic       xtal, busy, wr, rd, rd_d;
  logic [5:0] addr;
  logic [7:0] wdata, d0, d1;
  logic       sel_n, sclk, mosi, miso, miso_oe, pd_en, rx_vld, cmd_stb, irq;
  logic [5:0] cmd_code;
  logic [7:0] rdata, rx_byte, head;
  logic [6:0] count;
  logic [7:0] exp_q[$];            // expected results in order
  int         n_fail = 0;
  int         tests_run = 0;
  int         seed;
  always #50 core_clk_in = ~core_clk_in;
  spicp_master u_mst (.core_clk_in(core_clk_in), .miso_in(miso), .miso_oe_in(miso_oe),
    .pulldown_en_in(pd_en), .sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi),
    .rx_vld_out(rx_vld), .rx_byte_out(rx_byte));
  spicp_port u_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .sel_n_in(sel_n),
    .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
    .pulldown_en_out(pd_en), .xtal_stable_in(xtal), .cmd_busy_in(busy),
    .cmd_strobe_out(cmd_stb), .cmd_code_out(cmd_code), .irq_out(irq),
    .core_addr_in(addr), .core_wdata_in(wdata), .core_wr_in(wr), .core_rd_in(rd),
    .core_rdata_out(rdata), .core_push_in(1'b0), .core_push_data_in(8'h00),
    .core_pop_in(1'b0), .core_head_out(head), .fifo_count_out(count));
  // one comparison, counted
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // compare a result against the oldest note
  task take(input logic [7:0] seen);
    if (exp_q.size() == 0) check(seen, $isunknown(seen) ? 8'h00 : ~seen);
    else check(seen, exp_q.pop_front());
  endtask : take
  // verdict and end of run
  task close_out;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // core register write, one cycle
  task cwr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_in);
    wr    <= 1'b0;
  endtask : cwr
  // core register read, expectation noted first
  task crd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge core_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_in);
    rd   <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask : crd
  // one full serial read byte, expectation noted first
  task srd(input logic [7:0] e);
    exp_q.push_back(e);
    u_mst.xfer(8'h00, 8, 1'b1);
  endtask : srd
  // whole frame of up to three sent bytes; count 0 skips a byte
  task sfr(input logic [7:0] b0, b1, b2, input int n1, n2);
    u_mst.frame_open();
    u_mst.xfer(b0, 8, 1'b0);
    if (n1 > 0) u_mst.xfer(b1, n1, 1'b0);
    if (n2 > 0) u_mst.xfer(b2, n2, 1'b0);
    u_mst.frame_close();
  endtask : sfr
  // monitor: read data the cycle after the strobe, commands on their pulse
  always @(posedge core_clk_in) begin
    rd_d <= rd;
    if (rd_d) take(rdata);
    if (cmd_stb) take({2'h0, cmd_code});
  end
  // serial bytes as the master finishes them
  always @(posedge rx_vld) take(rx_byte);
  // hang guard
  initial begin
    #3000000;
    n_fail++;
    close_out();
  end
  // main sequence
  initial begin
    {xtal, busy, wr, rd, addr, wdata} = '0;
    seed = $urandom(32'h950B);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (12) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    check({7'h00, miso_oe}, 8'h00);
    sfr({MODE_REG_WR, 6'h03}, d0, d1, 8, 8);
    crd(6'h03, d0);
    crd(6'h04, d1);
    u_mst.frame_open();
    u_mst.xfer({MODE_REG_RD, 6'h03}, 8, 1'b0);
    srd(d0);
    srd(d1);
    u_mst.frame_close();
    $display("test write and read done");
    sfr({MODE_REG_WR, 6'h05}, ~d0, 8'h00, 5, 0);
    crd(6'h05, 8'h00);
    sfr({MODE_REG_WR, 6'h07}, d1, 8'hFF, 8, 8);
    crd(6'h07, d1);
    crd(6'h08, 8'h00);
    u_mst.frame_open();
    u_mst.xfer({MODE_REG_RD, 6'h20}, 8, 1'b0);
    srd(8'h00);
    u_mst.frame_close();
    $display("test partial and unmapped done");
    sfr({MODE_FIFO, TRL_LOAD}, d0, 8'h00, 8, 0);
    check({1'b0, count}, 8'h00);
    cwr(ADR_OPCTL, 8'h80);
    sfr({MODE_FIFO, TRL_LOAD}, d0, 8'h00, 8, 0);
    check({1'b0, count}, 8'h00);
    xtal <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    u_mst.frame_open();
    u_mst.xfer({MODE_FIFO, TRL_LOAD}, 8, 1'b0);
    u_mst.xfer(d0, 8, 1'b0);
    u_mst.xfer(d1, 8, 1'b0);
    u_mst.xfer(8'hA5, 3, 1'b0);
    u_mst.frame_close();
    check({1'b0, count}, 8'h02);
    check(head, d0);
    sfr({MODE_FIFO, TRL_READ}, 8'h00, 8'h00, 4, 0);
    check({1'b0, count}, 8'h02);
    u_mst.frame_open();
    u_mst.xfer({MODE_FIFO, TRL_READ}, 8, 1'b0);
    srd(d0);
    srd(d1);
    u_mst.frame_close();
    check({1'b0, count}, 8'h00);
    $display("test fifo done");
    exp_q.push_back(8'h05);
    u_mst.frame_open();
    u_mst.xfer({MODE_CMD, 6'h05}, 8, 1'b0);
    u_mst.xfer({MODE_REG_RD, 6'h03}, 8, 1'b0);
    srd(d0);
    u_mst.frame_close();
    exp_q.push_back(8'h31);
    sfr({MODE_CMD, 6'h31}, 8'h00, 8'h00, 0, 0);
    @(posedge core_clk_in);
    busy <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    busy <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    check({7'h00, irq}, 8'h01);
    $display("test commands done");
    cwr(ADR_IOCFG, 8'h10);
    repeat (2) @(posedge core_clk_in);
    check({6'h00, miso_oe, pd_en}, 8'h01);
    cwr(ADR_IOCFG, 8'h08);
    repeat (2) @(posedge core_clk_in);
    check({7'h00, pd_en}, 8'h01);
    cwr(ADR_IOCFG, 8'h00);
    repeat (2) @(posedge core_clk_in);
    check({7'h00, pd_en}, 8'h00);
    $display("test pull-down done");
    check(8'(exp_q.size()), 8'h00);
    close_out();
  end
endmodule : test_spicp_port
`default_nettype wire
